// ==== hw/memory_map_bank_decoder.v ====
// Purpose: program counter, program storage and banked data-file decode
// Assumes: core drives one data access per cycle, same clock as this block
// Notes: fetched words and core/RAM read data appear one cycle after the request, peripheral read data two
//
// How it works
// - A 13-bit program counter reaches an 8k by 14-bit instruction space.
// - Only word addresses 0000h to 07FFh exist in program storage.
// - Fetches above the 2k region wrap into it by dropping the upper counter bits.
// - Reset puts the program counter at 0000h.
// - Taking an interrupt loads the program counter with 0004h.
// - The lowest 32 locations of each of the two banks decode to special registers.
// - 20h-7Fh of bank 0 and A0h-BFh of bank 1 decode to general RAM.
// - F0h-FFh of bank 1 reach the same storage as 70h-7Fh of bank 0.
// - Every other data location is unimplemented and reads as zero.
// - Status bit 5 picks bank 0 when clear and bank 1 when set for direct accesses.
// - The general file holds 128 bytes, reachable directly or through the pointer.
// - An eight-deep hardware stack keeps return addresses for calls and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_regs.vh"

module memory_map_bank_decoder (
  input wire core_clk,
  input wire srst,
  // program flow from the core
  input wire pcStep,
  input wire pcJump,
  input wire [`PROG_ADDR_WIDTH-1:0] jumpTarget,
  input wire callEn,
  input wire retEn,
  input wire intTake,
  // program storage load port
  input wire progWrEn,
  input wire [`PROG_ADDR_WIDTH-1:0] progWrAddr,
  input wire [`INSTR_WIDTH-1:0] progWrData,
  // data file access
  input wire dataRd,
  input wire dataWr,
  input wire [6:0] fileAddr,
  input wire [7:0] dataWrData,
  input wire flagWe,
  input wire [`STATUS_FLAG_WIDTH-1:0] flagIn,
  input wire [7:0] periphRdData,
  // outputs
  output reg [`PC_WIDTH-1:0] pc_q,
  output reg [`INSTR_WIDTH-1:0] instrWord_q,
  output reg [7:0] rdData_q,
  output reg rdValid_q,
  output reg [7:0] coreStatus_q,
  output reg [7:0] indirectPointer_q,
  output reg periphRd_q,
  output reg periphWr_q,
  output reg [7:0] periphAddr_q,
  output reg [7:0] periphWrData_q
);
  reg [`INSTR_WIDTH-1:0] progMem [0:`PROG_DEPTH-1];
  reg [7:0] generalRam [0:`GPR_DEPTH-1];
  reg [`PC_LATCH_WIDTH-1:0] pcLatch_q;
  reg [2:0] rdKind_q;
  reg [`PC_WIDTH-1:0] pc_d;

  wire [`PC_WIDTH-1:0] stackTop;
  wire [`PC_WIDTH-1:0] pcNext;
  wire [7:0] directAddr;
  wire [7:0] effAddr;
  wire [2:0] kind;
  wire [`GPR_IDX_WIDTH-1:0] gprIdx;
  wire pushReq;
  wire popReq;
  wire pclWrite;
  wire access;

  // classify a full 8-bit file address
  function [2:0] decodeKind;
    input [7:0] a;
    begin
      if (a[6:0] < `SFR_AREA_SIZE) begin
        case (a[6:0])
          `OFS_INDIRECT: decodeKind = `KIND_INDIRECT;
          `OFS_PC_LOW: decodeKind = `KIND_PC_LOW;
          `OFS_CORE_STATUS: decodeKind = `KIND_STATUS;
          `OFS_INDIRECT_POINTER: decodeKind = `KIND_POINTER;
          `OFS_PC_LATCH: decodeKind = `KIND_PC_LATCH;
          default: decodeKind = `KIND_PERIPH;
        endcase
      end else if (a >= `GPR_B0_LO && a <= `GPR_B0_HI) begin
        decodeKind = `KIND_GPR;
      end else if (a >= `GPR_B1_LO && a <= `GPR_B1_HI) begin
        decodeKind = `KIND_GPR;
      end else if (a >= `ALIAS_LO) begin
        decodeKind = `KIND_GPR;
      end else begin
        decodeKind = `KIND_UNIMPL;
      end
    end
  endfunction

  // map a general-area address onto the 128-byte file
  function [`GPR_IDX_WIDTH-1:0] gprIndex;
    input [7:0] a;
    begin
      if (a >= `ALIAS_LO && a <= `ALIAS_HI) begin
        // shares bytes with 70h-7Fh of bank 0
        gprIndex = `ALIAS_BASE + {3'h0, a[3:0]};
      end else if (a[7]) begin
        gprIndex = `GPR_B1_BASE + {2'h0, a[4:0]};
      end else begin
        gprIndex = a[6:0] - `SFR_AREA_SIZE;
      end
    end
  endfunction

  // direct accesses take the bank from the status bank bit
  assign directAddr = {coreStatus_q[`STATUS_BANK_BIT], fileAddr};
  // reserved indirect bank bit is not used: pointer alone covers both banks
  assign effAddr = (fileAddr == `OFS_INDIRECT) ? indirectPointer_q : directAddr;
  // pointer aimed at the indirect location itself reads zero, writes nothing
  assign kind = (decodeKind(effAddr) == `KIND_INDIRECT) ? `KIND_UNIMPL : decodeKind(effAddr);
  assign gprIdx = gprIndex(effAddr);
  assign access = dataRd | dataWr;
  assign pclWrite = dataWr && kind == `KIND_PC_LOW;

  assign pushReq = intTake | (callEn & ~retEn);
  assign popReq = retEn & ~intTake;
  assign pcNext = pc_q + 13'h0001;

  return_stack stack_i (
    .core_clk(core_clk),
    .srst(srst),
    .push(pushReq),
    .pop(popReq),
    .pushAddr(intTake ? pc_q : pcNext),
    .topAddr(stackTop)
  );

  // next program counter, interrupt first
  always @* begin
    pc_d = pc_q;
    if (intTake) begin
      pc_d = `INT_VECTOR;
    end else if (retEn) begin
      pc_d = stackTop;
    end else if (callEn || pcJump) begin
      pc_d = {pcLatch_q[4:3], jumpTarget};
    end else if (pclWrite) begin
      pc_d = {pcLatch_q, dataWrData};
    end else if (pcStep) begin
      pc_d = pcNext;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      pc_q <= `RESET_VECTOR;
    end else begin
      pc_q <= pc_d;
    end
  end

  // upper counter bits are dropped so fetches above 07FFh wrap
  always @(posedge core_clk) begin
    if (progWrEn) begin
      progMem[progWrAddr] <= progWrData;
    end
    instrWord_q <= progMem[pc_q[`PROG_ADDR_WIDTH-1:0]];
  end

  // general RAM has no reset, as in real static RAM
  always @(posedge core_clk) begin
    if (dataWr && kind == `KIND_GPR) begin
      generalRam[gprIdx] <= dataWrData;
    end
  end

  // core registers; bits 7:6 stored as written, software keeps them clear
  always @(posedge core_clk) begin
    if (srst) begin
      coreStatus_q <= `STATUS_RESET;
      indirectPointer_q <= 8'h00;
      pcLatch_q <= 5'h00;
    end else begin
      if (dataWr && kind == `KIND_STATUS) begin
        // software write to status wins over the flag update
        coreStatus_q <= dataWrData;
      end else if (flagWe) begin
        coreStatus_q[`STATUS_FLAG_WIDTH-1:0] <= flagIn;
      end
      if (dataWr && kind == `KIND_POINTER) begin
        indirectPointer_q <= dataWrData;
      end
      if (dataWr && kind == `KIND_PC_LATCH) begin
        pcLatch_q <= dataWrData[`PC_LATCH_WIDTH-1:0];
      end
    end
  end

  // peripheral special registers are forwarded, one-cycle strobes
  always @(posedge core_clk) begin
    if (srst) begin
      periphRd_q <= 1'b0;
      periphWr_q <= 1'b0;
      periphAddr_q <= 8'h00;
      periphWrData_q <= 8'h00;
    end else begin
      periphRd_q <= dataRd && kind == `KIND_PERIPH;
      periphWr_q <= dataWr && kind == `KIND_PERIPH;
      if (access && kind == `KIND_PERIPH) begin
        periphAddr_q <= effAddr;
        periphWrData_q <= dataWrData;
      end
    end
  end

  // read pipeline: kind captured now, data selected next cycle
  always @(posedge core_clk) begin
    if (srst) begin
      rdKind_q <= `KIND_UNIMPL;
    end else begin
      rdKind_q <= kind;
    end
  end

  // peripheral data is sampled at the edge that ends the cycle in which periphRd_q is high
  always @(posedge core_clk) begin
    if (srst) begin
      rdValid_q <= 1'b0;
      rdData_q <= 8'h00;
    end else begin
      rdValid_q <= dataRd;
      if (dataRd) begin
        case (kind)
          `KIND_GPR: rdData_q <= generalRam[gprIdx];
          `KIND_STATUS: rdData_q <= coreStatus_q;
          `KIND_POINTER: rdData_q <= indirectPointer_q;
          `KIND_PC_LOW: rdData_q <= pc_q[7:0];
          `KIND_PC_LATCH: rdData_q <= {3'h0, pcLatch_q};
          `KIND_PERIPH: rdData_q <= 8'h00;
          default: rdData_q <= 8'h00;
        endcase
      end else if (rdValid_q && rdKind_q == `KIND_PERIPH) begin
        rdData_q <= periphRdData;
      end
    end
  end
endmodule

`default_nettype wire

// ==== common/memory_map_regs.vh ====
// Purpose: shared constants for the memory map and bank decoder
// Assumes: 8-bit data file, 14-bit instruction words
// Notes: file addresses are full 8-bit values, bank bit in position 7
`ifndef MEMORY_MAP_REGS_VH
`define MEMORY_MAP_REGS_VH

`define PC_WIDTH 13
`define PROG_ADDR_WIDTH 11
`define PROG_DEPTH 2048
`define INSTR_WIDTH 14
`define RESET_VECTOR 13'h0000
`define INT_VECTOR 13'h0004

`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3

`define GPR_DEPTH 128
`define GPR_IDX_WIDTH 7

// core register locations within a bank (low seven address bits)
`define OFS_INDIRECT 7'h00
`define OFS_PC_LOW 7'h02
`define OFS_CORE_STATUS 7'h03
`define OFS_INDIRECT_POINTER 7'h04
`define OFS_PC_LATCH 7'h0A

// area bounds, full 8-bit file addresses
`define SFR_AREA_SIZE 7'h20
`define GPR_B0_LO 8'h20
`define GPR_B0_HI 8'h7F
`define GPR_B1_LO 8'hA0
`define GPR_B1_HI 8'hBF
`define ALIAS_LO 8'hF0
`define ALIAS_HI 8'hFF
`define GPR_B1_BASE 7'h60
`define ALIAS_BASE 7'h50

// core status fields
`define STATUS_BANK_BIT 5
`define STATUS_RSV_HI 6
`define STATUS_RSV_IND 7
`define STATUS_FLAG_WIDTH 3
`define STATUS_RESET 8'h18
`define PC_LATCH_WIDTH 5

// decode kinds
`define KIND_UNIMPL 3'h0
`define KIND_GPR 3'h1
`define KIND_PERIPH 3'h2
`define KIND_STATUS 3'h3
`define KIND_POINTER 3'h4
`define KIND_PC_LOW 3'h5
`define KIND_PC_LATCH 3'h6
`define KIND_INDIRECT 3'h7

`endif

// ==== hw/return_stack.v ====
// Purpose: circular return-address stack for calls and interrupts
// Assumes: push and pop are never asked for in the same cycle
// Notes: a ninth push overwrites the oldest entry, no overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_regs.vh"

module return_stack (
  input wire core_clk,
  input wire srst,
  input wire push,
  input wire pop,
  input wire [`PC_WIDTH-1:0] pushAddr,
  output wire [`PC_WIDTH-1:0] topAddr
);
  reg [`PC_WIDTH-1:0] entry [0:`STACK_DEPTH-1];
  reg [`STACK_PTR_WIDTH-1:0] ptr_q;
  wire [`STACK_PTR_WIDTH-1:0] topIdx;

  assign topIdx = ptr_q - 3'h1;
  assign topAddr = entry[topIdx];

  always @(posedge core_clk) begin
    if (srst) begin
      ptr_q <= 3'h0;
    end else if (push) begin
      // eight entries deep, pointer wraps
      entry[ptr_q] <= pushAddr;
      ptr_q <= ptr_q + 3'h1;
    end else if (pop) begin
      ptr_q <= topIdx;
    end
  end
endmodule

`default_nettype wire

// ==== tb/memory_map_bank_decoder_asserts.sv ====
// Purpose: port checks on the memory map and bank decoder
// Assumes: one clock, srst synchronous active high
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module memory_map_bank_decoder_asserts (
  input wire core_clk,
  input wire srst,
  input wire pcStep,
  input wire pcJump,
  input wire [10:0] jumpTarget,
  input wire callEn,
  input wire retEn,
  input wire intTake,
  input wire dataRd,
  input wire dataWr,
  input wire [6:0] fileAddr,
  input wire [7:0] dataWrData,
  input wire [7:0] periphRdData,
  input wire [12:0] pc_q,
  input wire [7:0] rdData_q,
  input wire rdValid_q,
  input wire [7:0] coreStatus_q,
  input wire [7:0] indirectPointer_q,
  input wire periphRd_q,
  input wire [7:0] periphAddr_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // low special locations that are not core registers go out to the peripherals
  wire pRd = dataRd && fileAddr[6:5] == 2'h0 && fileAddr != 7'h00 && fileAddr != 7'h02
    && fileAddr != 7'h03 && fileAddr != 7'h04 && fileAddr != 7'h0A;
  wire quiet = !intTake && !retEn && !callEn && !pcJump && !dataWr;
  sequence sIntRet;
    intTake ##1 (retEn && !intTake);
  endsequence
  // a read in the next cycle legally replaces the peripheral data
  sequence sPeriphRd;
    pRd ##1 !dataRd;
  endsequence
  AST_RST_PC: assert property ($fell(srst) |-> pc_q == 13'h0000)
    else $error("pc not at zero after reset");
  AST_INT_VEC: assert property (intTake |=> pc_q == 13'h0004)
    else $error("interrupt vector wrong");
  AST_PC_STEP: assert property (pcStep && quiet |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("pc step wrong");
  AST_JUMP_LOW: assert property ((pcJump || callEn) && !intTake && !retEn |=> pc_q[10:0] == $past(jumpTarget))
    else $error("jump target wrong");
  AST_INT_RET: assert property (sIntRet |=> pc_q == $past(pc_q, 2))
    else $error("return after interrupt wrong");
  AST_BANK_WR: assert property (dataWr && fileAddr == 7'h03 |=> coreStatus_q == $past(dataWrData))
    else $error("status write lost");
  AST_PTR_WR: assert property (dataWr && fileAddr == 7'h04 |=> indirectPointer_q == $past(dataWrData))
    else $error("pointer write lost");
  AST_PERIPH: assert property (pRd |=> periphRd_q
    && periphAddr_q == {$past(coreStatus_q[5]), $past(fileAddr)})
    else $error("peripheral strobe wrong");
  AST_PERIPH_DATA: assert property (sPeriphRd |=> rdData_q == $past(periphRdData))
    else $error("peripheral read wrong");
  AST_UNIMPL: assert property (dataRd && coreStatus_q[5] && fileAddr >= 7'h40 && fileAddr <= 7'h6F
    |=> rdValid_q && rdData_q == 8'h00)
    else $error("unimplemented read not zero");
  AST_RD_VALID: assert property (dataRd |=> rdValid_q ##1 !rdValid_q || $past(dataRd))
    else $error("read valid wrong");
endmodule
bind memory_map_bank_decoder memory_map_bank_decoder_asserts u_chk (.*);
`default_nettype wire

// ==== tb/periph_model.sv ====
// Purpose: peripheral side answering special register reads
// Assumes: data is sampled while the read strobe stands
// Notes: outside a read the bus toggles so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic core_clk,
  input wire logic periphRd_q,
  input wire logic [7:0] periphAddr_q,
  output logic [7:0] periphRdData
);
  logic [7:0] noise_q = 8'hA5;
  always @(posedge core_clk) noise_q <= ~noise_q;
  assign periphRdData = periphRd_q ? ~periphAddr_q : noise_q;
endmodule
`default_nettype wire

// ==== tb/memory_map_bank_decoder_tb.sv ====
// Purpose: directed bench for the memory map and bank decoder
// Assumes: answers one cycle after each request, two after a peripheral read
// Notes: expectations come from the memory map, not the design
`timescale 1ns/1ps
`default_nettype none
module memory_map_bank_decoder_tb;
  logic core_clk = 0, srst = 1, pcStep = 0, pcJump = 0, callEn = 0, retEn = 0, intTake = 0;
  logic progWrEn = 0, dataRd = 0, dataWr = 0, flagWe = 0;
  logic [10:0] jumpTarget = 0, progWrAddr = 0;
  logic [13:0] progWrData = 0, instrWord_q;
  logic [6:0] fileAddr = 0;
  logic [7:0] dataWrData = 0, periphRdData, rdData_q, coreStatus_q, indirectPointer_q;
  logic [7:0] periphAddr_q, periphWrData_q;
  logic [2:0] flagIn = 0;
  logic [12:0] pc_q, stk [8];
  logic rdValid_q, periphRd_q, periphWr_q;
  int fails = 0, n_checks = 0;
  always #4 core_clk = ~core_clk;
  memory_map_bank_decoder u_dut (.*);
  periph_model u_per (.*);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk) {dataWr, fileAddr, dataWrData} <= {1'b1, a, d};
    @(posedge core_clk) dataWr <= 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk) {dataRd, fileAddr} <= {1'b1, a};
    @(posedge core_clk) dataRd <= 0;
    #1 chk("rdValid", 1, rdValid_q);
    chk("rdData", e, rdData_q);
  endtask
  task automatic fl(input logic [4:0] v, input logic [10:0] t);
    @(posedge core_clk) {intTake, retEn, callEn, pcJump, pcStep, jumpTarget} <= {v, t};
    @(posedge core_clk) {intTake, retEn, callEn, pcJump, pcStep} <= 0;
    #1;
  endtask
  task automatic pw(input logic [10:0] a, input logic [13:0] d);
    @(posedge core_clk) {progWrEn, progWrAddr, progWrData} <= {1'b1, a, d};
    @(posedge core_clk) progWrEn <= 0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 0;
    #1 chk("pc", 0, pc_q);
    chk("status", 8'h18, coreStatus_q);
    chk("pointer", 0, indirectPointer_q);
    pw(11'h000, 14'h1111);
    pw(11'h004, 14'h2AAA);
    pw(11'h7FF, 14'h3C3C);
    @(posedge core_clk) #1 chk("instr", 14'h1111, instrWord_q);
    fl(5'b10000, 0);
    chk("pc", 13'h0004, pc_q);
    @(posedge core_clk) #1 chk("instr", 14'h2AAA, instrWord_q);
    fl(5'b01000, 0);
    chk("pc", 0, pc_q);
    wr(7'h0A, 8'h18);
    fl(5'b00010, 11'h7FF);
    chk("pc", 13'h1FFF, pc_q);
    @(posedge core_clk) #1 chk("instr", 14'h3C3C, instrWord_q);
    fl(5'b00001, 0);
    chk("pc", 0, pc_q);
    for (int i = 0; i < 8; i++) begin
      stk[i] = pc_q + 13'h1;
      fl(5'b00100, 11'(i * 8 + 16));
      chk("pc", {2'b11, 11'(i * 8 + 16)}, pc_q);
    end
    for (int i = 7; i >= 0; i--) begin
      fl(5'b01000, 0);
      chk("pc", stk[i], pc_q);
    end
    // interrupt and return on consecutive edges
    @(posedge core_clk) intTake <= 1;
    @(posedge core_clk) {intTake, retEn} <= 2'b01;
    @(posedge core_clk) retEn <= 0;
    #1 chk("pc", stk[0], pc_q);
    wr(7'h02, 8'h34);
    #1 chk("pc", 13'h1834, pc_q);
    rd(7'h02, 8'h34);
    wr(7'h03, 8'h00);
    wr(7'h7F, 8'h5A);
    wr(7'h20, 8'h11);
    wr(7'h03, 8'h20);
    #1 chk("status", 8'h20, coreStatus_q);
    @(posedge core_clk) {flagWe, flagIn} <= {1'b1, 3'h5};
    @(posedge core_clk) flagWe <= 0;
    #1 chk("status", 8'h25, coreStatus_q);
    // software write and flag update in one cycle: the write wins
    @(posedge core_clk) {dataWr, fileAddr, dataWrData, flagWe, flagIn} <= {1'b1, 7'h03, 8'h20, 1'b1, 3'h7};
    @(posedge core_clk) {dataWr, flagWe} <= 0;
    #1 chk("status", 8'h20, coreStatus_q);
    rd(7'h7F, 8'h5A);
    wr(7'h20, 8'h22);
    rd(7'h20, 8'h22);
    wr(7'h40, 8'h77);
    rd(7'h40, 8'h00);
    wr(7'h04, 8'h20);
    rd(7'h00, 8'h11);
    rd(7'h05, 8'h00);
    chk("periphRd", 1, periphRd_q);
    @(posedge core_clk) #1 chk("periphData", 8'h7A, rdData_q);
    wr(7'h05, 8'h3C);
    #1 chk("periphWr", 1, periphWr_q);
    chk("periphAddr", 8'h85, periphAddr_q);
    chk("periphWrData", 8'h3C, periphWrData_q);
    @(posedge core_clk) #1 chk("periphWr", 0, periphWr_q);
    // second reset in mid-run
    @(posedge core_clk) srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    #1 chk("pc", 0, pc_q);
    chk("status", 8'h18, coreStatus_q);
    @(posedge core_clk) #1 chk("instr", 14'h1111, instrWord_q);
    stop_test;
  end
endmodule
`default_nettype wire
